// ===== rtl/radio_flags_pkg.sv
// constants, register map and carrier types for the radio status flag block
package radio_flags_pkg;

    // ==================================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_MODE_FLAGS  = 8'h27;
    localparam logic [7:0] IDX_QUEUE_FLAGS = 8'h28;
    localparam logic [7:0] IDX_LEVEL_THR   = 8'h29;
    localparam logic [7:0] IDX_START_TMO   = 8'h2A;
    localparam logic [7:0] IDX_THR_TMO     = 8'h2B;
    localparam logic [7:0] IDX_CONTROL     = 8'h70;

    // ==================================================================
    // values after reset
    localparam logic [7:0] LEVEL_THR_RESET = 8'hE4;
    localparam logic [7:0] START_TMO_RESET = 8'h00;
    localparam logic [7:0] THR_TMO_RESET   = 8'h00;
    localparam logic [7:0] MODE_FLAGS_RESET  = 8'h80;
    localparam logic [7:0] QUEUE_FLAGS_RESET = 8'h00;

    // ==================================================================
    // field positions and counts
    localparam int         LEVEL_BIT    = 3;
    localparam int         MATCH_BIT    = 0;
    localparam int         OVERFLOW_BIT = 4;
    localparam logic [6:0] QUEUE_DEPTH  = 7'h42;
    localparam logic [3:0] UNIT_BITS    = 4'hF;
    localparam logic [6:0] LEVEL_SETTING_RESET = 7'h0F;

    // ==================================================================
    // operating modes
    typedef enum logic [2:0] {
        MODE_SLEEP   = 3'h0,
        MODE_STANDBY = 3'h1,
        MODE_SYNTH   = 3'h2,
        MODE_TX      = 3'h3,
        MODE_RX      = 3'h4
    } radio_mode_t;

    // first flag register
    typedef struct packed {
        logic modeSettled;
        logic receiveSettled;
        logic transmitSettled;
        logic synthLocked;
        logic levelAbove;
        logic timedOut;
        logic intermediate;
        logic frameMatch;
    } mode_flags_t;

    // second flag register
    typedef struct packed {
        logic queueFull;
        logic queueNonempty;
        logic queueAboveLevel;
        logic queueOverflow;
        logic frameTransmitted;
        logic frameReceived;
        logic checksumGood;
        logic spare;
    } queue_flags_t;

    // control word, bits 12:0 of the control register
    typedef struct packed {
        logic [6:0]  queueLevelSetting;
        logic        keepBadChecksumFrames;
        logic        crcOn;
        logic        packetMode;
        radio_mode_t mode;
    } control_t;

    localparam control_t CONTROL_RESET = '{
        queueLevelSetting:     LEVEL_SETTING_RESET,
        keepBadChecksumFrames: 1'b0,
        crcOn:                 1'b1,
        packetMode:            1'b1,
        mode:                  MODE_STANDBY
    };

endpackage : radio_flags_pkg

// ===== rtl/radio_irq_status_flags.sv
// status flags, level threshold and receive timeouts of the packet radio, behind an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module radio_irq_status_flags (
    // clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // apb slave
    input  wire logic [11:0]                  paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // readiness and measurement from the radio core
    input  wire logic                         sleepEntered,
    input  wire logic                         xoRunning,
    input  wire logic                         synthLock,
    input  wire logic                         samplingStarted,
    input  wire logic                         rampDone,
    input  wire logic                         rxChainSettled,
    input  wire logic [7:0]                   signalLevelReading,
    input  wire logic                         bitTick,
    input  wire logic                         intermediateActive,
    // events from the queue and packet engine
    input  wire logic [6:0]                   queueCount,
    input  wire logic                         overflowEvent,
    input  wire logic                         frameSentEvent,
    input  wire logic                         lastByteEvent,
    input  wire logic                         checksumPass,
    input  wire logic                         frameMatchEvent,
    // to the radio core
    output radio_flags_pkg::control_t         control,
    output logic                              queueFlush,
    output radio_flags_pkg::mode_flags_t      modeFlags,
    output radio_flags_pkg::queue_flags_t     queueFlags
);

    // every check below runs on the one clock and sleeps through reset
    default clocking dflt @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==================================================================
    // registers
    radio_flags_pkg::control_t     control_r;
    radio_flags_pkg::mode_flags_t  modeFlags_r;
    radio_flags_pkg::mode_flags_t  modeFlags_nxt;
    radio_flags_pkg::queue_flags_t queueFlags_r;
    radio_flags_pkg::queue_flags_t queueFlags_nxt;
    logic [7:0]  levelThr_r;
    logic [7:0]  startTmo_r;
    logic [7:0]  thrTmo_r;
    logic [31:0] prdata_r;
    logic        queueFlush_r;
    logic        wasRx_r;
    logic        wasLevel_r;
    logic        wasQueued_r;

    // ==================================================================
    // bus decode
    wire logic [7:0] regIdx     = paddr[9:2];
    wire logic       addrOk     = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    wire logic       hitMode    = addrOk && (regIdx == radio_flags_pkg::IDX_MODE_FLAGS);
    wire logic       hitQueue   = addrOk && (regIdx == radio_flags_pkg::IDX_QUEUE_FLAGS);
    wire logic       hitThr     = addrOk && (regIdx == radio_flags_pkg::IDX_LEVEL_THR);
    wire logic       hitStart   = addrOk && (regIdx == radio_flags_pkg::IDX_START_TMO);
    wire logic       hitThrTmo  = addrOk && (regIdx == radio_flags_pkg::IDX_THR_TMO);
    wire logic       hitCtrl    = addrOk && (regIdx == radio_flags_pkg::IDX_CONTROL);
    wire logic       hitAny     = hitMode | hitQueue | hitThr | hitStart | hitThrTmo | hitCtrl;
    wire logic       setupPhase = psel && !penable;
    wire logic       accessWr   = psel && penable && pwrite && hitAny;
    wire logic       lowLane    = pstrb[0];

    // answer in the first access cycle; read data was captured in setup
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !hitAny;
    assign prdata  = prdata_r;

    // read mux; reading has no side effect on any flag
    wire logic [31:0] readMux =
        hitMode   ? {24'h0, modeFlags_r}  :
        hitQueue  ? {24'h0, queueFlags_r} :
        hitThr    ? {24'h0, levelThr_r}   :
        hitStart  ? {24'h0, startTmo_r}   :
        hitThrTmo ? {24'h0, thrTmo_r}     :
        hitCtrl   ? {19'h0, control_r}    : 32'h0;

    // ==================================================================
    // write strobes
    wire logic wrCtrl     = accessWr && hitCtrl;
    wire logic wrLow      = accessWr && lowLane;
    radio_flags_pkg::radio_mode_t newMode;
    assign newMode = radio_flags_pkg::radio_mode_t'(pwdata[2:0]);
    wire logic modeChange = wrCtrl && lowLane && (newMode != control_r.mode);
    wire logic clrLevel   = wrLow && hitMode && pwdata[radio_flags_pkg::LEVEL_BIT];
    wire logic clrMatch   = wrLow && hitMode && pwdata[radio_flags_pkg::MATCH_BIT] && !control_r.packetMode;
    wire logic flushReq   = wrLow && hitQueue && pwdata[radio_flags_pkg::OVERFLOW_BIT];

    // ==================================================================
    // mode and queue conditions
    wire logic modeRx    = (control_r.mode == radio_flags_pkg::MODE_RX);
    wire logic modeTx    = (control_r.mode == radio_flags_pkg::MODE_TX);
    wire logic lockMode  = modeRx || modeTx || (control_r.mode == radio_flags_pkg::MODE_SYNTH);
    wire logic rxEntry   = modeRx && !wasRx_r;
    wire logic queueEmpty = (queueCount == 7'h00);
    wire logic emptied    = wasQueued_r && queueEmpty;
    wire logic levelSet  = modeRx && (signalLevelReading > levelThr_r);
    wire logic levelRise = modeFlags_r.levelAbove && !wasLevel_r;
    wire logic payloadOk = lastByteEvent && (!control_r.crcOn || control_r.keepBadChecksumFrames || checksumPass);

    // readiness of whichever mode is now requested
    logic mode_settled_flag;
    always_comb begin
        case (control_r.mode)
            radio_flags_pkg::MODE_SLEEP:   mode_settled_flag = sleepEntered;
            radio_flags_pkg::MODE_STANDBY: mode_settled_flag = xoRunning;
            radio_flags_pkg::MODE_SYNTH:   mode_settled_flag = synthLock;
            radio_flags_pkg::MODE_RX:      mode_settled_flag = samplingStarted;
            radio_flags_pkg::MODE_TX:      mode_settled_flag = rampDone;
            default:                       mode_settled_flag = 1'b0;
        endcase
    end

    // ==================================================================
    // receive timeouts: 0 counts from receive entry, 1 from the level flag
    wire logic [1:0] tmrFire;
    wire logic [7:0] tmrSetting [2];
    wire logic       tmrStart   [2];
    wire logic       tmrStop    [2];
    assign tmrSetting[0] = startTmo_r;
    assign tmrSetting[1] = thrTmo_r;
    assign tmrStart[0]   = rxEntry;
    assign tmrStart[1]   = levelRise;
    assign tmrStop[0]    = !modeRx || modeFlags_r.levelAbove;
    assign tmrStop[1]    = !modeRx || queueFlags_r.frameReceived;

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : gTimer
            logic [11:0] bits_r;
            logic        run_r;
            wire  logic  armed   = tmrSetting[t] != 8'h00;
            wire  logic  lastBit = bits_r == {tmrSetting[t] - 8'h01, radio_flags_pkg::UNIT_BITS};  // setting*16-1
            assign tmrFire[t] = run_r && !tmrStop[t] && bitTick && lastBit;
            // the count is in bit periods; setting times 16 is reached on the last bit tick
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    bits_r <= 12'h000;
                    run_r  <= 1'b0;
                end else if (tmrStart[t] && armed && !tmrStop[t]) begin
                    bits_r <= 12'h000;
                    run_r  <= 1'b1;
                end else if (tmrStop[t] || tmrFire[t]) begin
                    bits_r <= 12'h000;
                    run_r  <= 1'b0;
                end else if (run_r && bitTick) begin
                    bits_r <= bits_r + 12'h001;
                end
            end
        end
    endgenerate

    // ==================================================================
    // next flag values; a set wins over a clear in the same cycle, except modeSettled, where a mode change wins, and the queue level flags, where a flush wins
    always_comb begin
        modeFlags_nxt = modeFlags_r;
        queueFlags_nxt = queueFlags_r;
        // a mode change clears; readiness of the old mode is stale that cycle
        if (modeChange)
            modeFlags_nxt.modeSettled = 1'b0;
        else if (mode_settled_flag)
            modeFlags_nxt.modeSettled = 1'b1;
        modeFlags_nxt.receiveSettled  = modeRx && (modeFlags_r.receiveSettled || rxChainSettled);
        modeFlags_nxt.transmitSettled = modeTx && (modeFlags_r.transmitSettled || rampDone);
        modeFlags_nxt.synthLocked     = lockMode && synthLock;
        modeFlags_nxt.levelAbove      = levelSet || (modeRx && modeFlags_r.levelAbove && !clrLevel);
        modeFlags_nxt.timedOut        = (|tmrFire) || (modeRx && modeFlags_r.timedOut && !emptied);
        // following the sequencer level also covers its delayed sleep-mode edges
        modeFlags_nxt.intermediate    = intermediateActive;
        modeFlags_nxt.frameMatch      = (modeRx && frameMatchEvent)
                                      || (modeRx && modeFlags_r.frameMatch && !emptied && !clrMatch);
        queueFlags_nxt.queueFull       = queueCount == radio_flags_pkg::QUEUE_DEPTH;
        queueFlags_nxt.queueNonempty   = !queueEmpty;
        queueFlags_nxt.queueAboveLevel = queueCount > control_r.queueLevelSetting;
        queueFlags_nxt.queueOverflow   = (overflowEvent && control_r.mode != radio_flags_pkg::MODE_SLEEP)
                                       || (queueFlags_r.queueOverflow && !flushReq);
        queueFlags_nxt.frameTransmitted = modeTx && (queueFlags_r.frameTransmitted || frameSentEvent);
        queueFlags_nxt.frameReceived   = (modeRx && payloadOk)
                                       || (queueFlags_r.frameReceived && !queueEmpty && !flushReq);
        queueFlags_nxt.checksumGood    = (modeRx && lastByteEvent && checksumPass)
                                       || (queueFlags_r.checksumGood && !queueEmpty && !flushReq);
        queueFlags_nxt.spare           = 1'b0;
        // a flush empties the queue at once, so the level flags drop with it
        if (flushReq) begin
            queueFlags_nxt.queueFull       = 1'b0;
            queueFlags_nxt.queueNonempty   = 1'b0;
            queueFlags_nxt.queueAboveLevel = 1'b0;
        end
    end

    // ==================================================================
    // flag and history registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            modeFlags_r  <= radio_flags_pkg::mode_flags_t'(radio_flags_pkg::MODE_FLAGS_RESET);
            queueFlags_r <= radio_flags_pkg::queue_flags_t'(radio_flags_pkg::QUEUE_FLAGS_RESET);
            wasRx_r      <= 1'b0;
            wasLevel_r   <= 1'b0;
            wasQueued_r  <= 1'b0;
            queueFlush_r <= 1'b0;
        end else begin
            modeFlags_r  <= modeFlags_nxt;
            queueFlags_r <= queueFlags_nxt;
            wasRx_r      <= modeRx;
            wasLevel_r   <= modeFlags_r.levelAbove;
            wasQueued_r  <= !queueEmpty;
            queueFlush_r <= flushReq;
        end
    end

    // software settings
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            control_r  <= radio_flags_pkg::CONTROL_RESET;
            levelThr_r <= radio_flags_pkg::LEVEL_THR_RESET;
            startTmo_r <= radio_flags_pkg::START_TMO_RESET;
            thrTmo_r   <= radio_flags_pkg::THR_TMO_RESET;
        end else if (accessWr) begin
            if (hitCtrl && lowLane)
                control_r[7:0] <= pwdata[7:0];
            if (hitCtrl && pstrb[1])
                control_r[12:8] <= pwdata[12:8];
            if (hitThr && lowLane)
                levelThr_r <= pwdata[7:0];
            if (hitStart && lowLane)
                startTmo_r <= pwdata[7:0];
            if (hitThrTmo && lowLane)
                thrTmo_r <= pwdata[7:0];
        end
    end

    // read data is latched in setup so the access cycle can answer at once
    always_ff @(posedge clk) begin
        if (!rst_b)
            prdata_r <= 32'h0;
        else if (setupPhase)
            prdata_r <= readMux;
    end

    assign control    = control_r;
    assign queueFlush = queueFlush_r;
    assign modeFlags  = modeFlags_r;
    assign queueFlags = queueFlags_r;

    // ==================================================================
    // checks
    chk_mode_change: assert property (@(posedge clk) disable iff (!rst_b)
        modeChange |=> !modeFlags_r.modeSettled) else $error("mode settled not cleared on mode change");
    chk_rx_leave: assert property (@(posedge clk) disable iff (!rst_b)
        !modeRx |=> !modeFlags_r.receiveSettled) else $error("receive settled held outside receive");
    chk_tx_leave: assert property (@(posedge clk) disable iff (!rst_b)
        !modeTx |=> !modeFlags_r.transmitSettled && !queueFlags_r.frameTransmitted)
        else $error("transmit flags held outside transmit");
    chk_lock_track: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 modeFlags_r.synthLocked == ($past(synthLock) && $past(lockMode)))
        else $error("synth locked flag does not track lock");
    chk_level_clear: assert property (@(posedge clk) disable iff (!rst_b)
        clrLevel && !levelSet |=> !modeFlags_r.levelAbove) else $error("level flag not cleared by write");
    chk_queue_full: assert property (@(posedge clk) disable iff (!rst_b)
        !flushReq |=> queueFlags_r.queueFull == ($past(queueCount) == radio_flags_pkg::QUEUE_DEPTH))
        else $error("queue full flag wrong");
    chk_queue_level: assert property (@(posedge clk) disable iff (!rst_b)
        !flushReq && queueCount <= control_r.queueLevelSetting |=> !queueFlags_r.queueAboveLevel)
        else $error("queue level flag high at or below setting");
    chk_flush_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        flushReq && !overflowEvent |=> queueFlush && !queueFlags_r.queueOverflow ##1 !queueFlush)
        else $error("overflow write did not flush once");
    chk_match_ro: assert property (@(posedge clk) disable iff (!rst_b)
        control_r.packetMode && modeRx && modeFlags_r.frameMatch && !emptied |=> modeFlags_r.frameMatch)
        else $error("frame match cleared in packet mode");

    chk_rx_ready_set: assert property (modeRx && rxChainSettled |=> modeFlags_r.receiveSettled)
        else $error("receive settled not set");

    chk_level_set: assert property (levelSet |=> modeFlags_r.levelAbove)
        else $error("level flag not set");

    chk_timeout_set: assert property (|tmrFire |=> modeFlags_r.timedOut)
        else $error("timeout flag not set");

    chk_timeout_leave: assert property (!modeRx |=> !modeFlags_r.timedOut)
        else $error("timeout flag held outside receive");

    chk_match_leave: assert property (!modeRx |=> !modeFlags_r.frameMatch)
        else $error("frame match held outside receive");

    chk_intermediate_lag: assert property (##1 modeFlags_r.intermediate == $past(intermediateActive))
        else $error("intermediate flag does not follow sequencer");

    chk_queue_nonempty: assert property (!flushReq
        |=> queueFlags_r.queueNonempty == ($past(queueCount) != 7'h00)) else $error("nonempty flag wrong");

    chk_overflow_set: assert property (overflowEvent
        && control_r.mode != radio_flags_pkg::MODE_SLEEP |=> queueFlags_r.queueOverflow) else $error("overflow not set");

    chk_sent_set: assert property (modeTx && frameSentEvent |=> queueFlags_r.frameTransmitted)
        else $error("frame transmitted not set");

    chk_payload_set: assert property (modeRx && payloadOk |=> queueFlags_r.frameReceived)
        else $error("frame received not set");

    chk_empty_clear: assert property (queueEmpty && !lastByteEvent
        |=> !queueFlags_r.frameReceived && !queueFlags_r.checksumGood) else $error("received flags held while empty");

    chk_mode_ready: assert property (!modeChange && mode_settled_flag |=> modeFlags_r.modeSettled)
        else $error("mode settled not set when ready");

endmodule : radio_irq_status_flags

`default_nettype wire

// ===== tb/radio_core_model.sv
// behavioural model of the radio core that feeds readiness levels and bit ticks
`timescale 1ns/1ps
`default_nettype none
module radio_core_model (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // requested mode from the flag block
    input  wire radio_flags_pkg::control_t control,
    // readiness levels and bit timing
    output logic                           sleepEntered,
    output logic                           xoRunning,
    output logic                           synthLock,
    output logic                           samplingStarted,
    output logic                           rampDone,
    output logic                           rxChainSettled,
    output logic                           bitTick,
    output logic                           intermediateActive
);
    logic [1:0] tickCount_r;

    // =========================================
    // readiness follows the mode at once: the fastest core the block may meet
    assign sleepEntered       = (control.mode == radio_flags_pkg::MODE_SLEEP);
    assign xoRunning          = !sleepEntered;
    assign synthLock          = (control.mode inside {radio_flags_pkg::MODE_SYNTH, radio_flags_pkg::MODE_TX,
                                                      radio_flags_pkg::MODE_RX});
    assign samplingStarted    = (control.mode == radio_flags_pkg::MODE_RX);
    assign rxChainSettled     = samplingStarted;
    assign rampDone           = (control.mode == radio_flags_pkg::MODE_TX);
    assign intermediateActive = 1'b0;  // no automatic sequencer in this model
    assign bitTick            = (tickCount_r == 2'h3);

    // one bit period is four clocks, short enough to reach the timeouts quickly
    always_ff @(posedge clk) begin
        if (!rst_b) tickCount_r <= 2'h0;
        else tickCount_r <= tickCount_r + 2'h1;
    end
endmodule : radio_core_model
`default_nettype wire

// ===== tb/tb_radio_irq_status_flags.sv
// self-checking bench for the radio status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_radio_irq_status_flags;
    // =========================================
    // stimulus and observed signals
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rdq, prdata;
    logic [7:0]  level = 8'h00;
    logic [6:0]  qCount = 7'h00;
    logic        ovf = 1'b0, lastByte = 1'b0, ckPass = 1'b0, match = 1'b0, sent = 1'b0, errq;
    logic        pready, pslverr, queueFlush, sleepEn, xoRun, lock, sampling, ramp, rxSet, tick, inter;
    radio_flags_pkg::control_t     control;
    radio_flags_pkg::mode_flags_t  modeFlags;
    radio_flags_pkg::queue_flags_t queueFlags;
    int          badCount = 0, checksDone = 0;

    always #20 clk = ~clk;

    radio_irq_status_flags u_radio_irq_status_flags (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleepEntered(sleepEn), .xoRunning(xoRun), .synthLock(lock),
        .samplingStarted(sampling), .rampDone(ramp), .rxChainSettled(rxSet), .signalLevelReading(level),
        .bitTick(tick), .intermediateActive(inter), .queueCount(qCount), .overflowEvent(ovf),
        .frameSentEvent(sent), .lastByteEvent(lastByte), .checksumPass(ckPass), .frameMatchEvent(match),
        .control(control), .queueFlush(queueFlush), .modeFlags(modeFlags), .queueFlags(queueFlags));

    radio_core_model u_radio_core_model (.clk(clk), .rst_b(rst_b), .control(control), .sleepEntered(sleepEn),
        .xoRunning(xoRun), .synthLock(lock), .samplingStarted(sampling), .rampDone(ramp),
        .rxChainSettled(rxSet), .bitTick(tick), .intermediateActive(inter));

    // =========================================
    // shared helpers
    function automatic logic [11:0] adr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : adr

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one apb transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, adr(idx), 32'h0000_0000);
        check(rdq, exp);
    endtask : rd

    // =========================================
    // scenarios
    task automatic reset_values();
        rd(radio_flags_pkg::IDX_MODE_FLAGS, 32'h0000_0080);
        rd(radio_flags_pkg::IDX_QUEUE_FLAGS, 32'h0000_0000);
        rd(radio_flags_pkg::IDX_LEVEL_THR, 32'h0000_00E4);
        rd(radio_flags_pkg::IDX_START_TMO, 32'h0000_0000);
        rd(radio_flags_pkg::IDX_THR_TMO, 32'h0000_0000);
        apb(1'b0, 12'h3F0, 32'h0000_0000);
        check({31'h0, errq}, 32'h0000_0001);
        $display("test reset_values done");
    endtask : reset_values

    task automatic queue_levels();
        logic [6:0] cnt [4];
        logic [7:0] exp [4];
        cnt = '{7'h42, 7'h10, 7'h0F, 7'h00};
        exp = '{8'hE0, 8'h60, 8'h40, 8'h00};
        for (int i = 0; i < 4; i++) begin
            qCount <= cnt[i];
            repeat (2) @(posedge clk);
            check({24'h0, queueFlags}, {24'h0, exp[i]});
        end
        $display("test queue_levels done");
    endtask : queue_levels

    task automatic overflow_flush();
        qCount <= 7'h10;
        ovf <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        repeat (2) @(posedge clk);
        check({24'h0, queueFlags}, 32'h0000_0070);
        rd(radio_flags_pkg::IDX_QUEUE_FLAGS, 32'h0000_0070);
        check({24'h0, queueFlags}, 32'h0000_0070);
        apb(1'b1, adr(radio_flags_pkg::IDX_QUEUE_FLAGS), 32'h0000_0010);
        #1;
        check({31'h0, queueFlush}, 32'h0000_0001);
        check({24'h0, queueFlags}, 32'h0000_0000);
        @(posedge clk);
        qCount <= 7'h00;
        $display("test overflow_flush done");
    endtask : overflow_flush

    task automatic receive_flow();
        apb(1'b1, adr(radio_flags_pkg::IDX_LEVEL_THR), 32'h0000_0080);
        apb(1'b1, adr(radio_flags_pkg::IDX_START_TMO), 32'h0000_0001);
        apb(1'b1, adr(radio_flags_pkg::IDX_CONTROL), 32'h0000_03DC);
        repeat (40) @(posedge clk);
        check({29'h0, modeFlags.receiveSettled, modeFlags.synthLocked, modeFlags.timedOut}, 32'h6);
        repeat (40) @(posedge clk);
        check({31'h0, modeFlags.timedOut}, 32'h1);
        level <= 8'h80;
        repeat (3) @(posedge clk);
        check({31'h0, modeFlags.levelAbove}, 32'h0);
        level <= 8'h81;
        repeat (3) @(posedge clk);
        check({31'h0, modeFlags.levelAbove}, 32'h1);
        level <= 8'h00;
        apb(1'b1, adr(radio_flags_pkg::IDX_MODE_FLAGS), 32'h0000_0009);
        #1;
        check({31'h0, modeFlags.levelAbove}, 32'h0);
        @(posedge clk);
        qCount <= 7'h05;
        lastByte <= 1'b1;
        ckPass <= 1'b1;
        match <= 1'b1;
        @(posedge clk);
        lastByte <= 1'b0;
        match <= 1'b0;
        repeat (2) @(posedge clk);
        check({24'h0, queueFlags}, 32'h0000_0046);
        check({31'h0, modeFlags.frameMatch}, 32'h1);
        qCount <= 7'h00;
        repeat (2) @(posedge clk);
        check({22'h0, queueFlags, modeFlags.timedOut, modeFlags.frameMatch}, 32'h0);
        apb(1'b1, adr(radio_flags_pkg::IDX_CONTROL), 32'h0000_03D9);
        #1;
        check({31'h0, modeFlags.modeSettled}, 32'h0);
        check({19'h0, control}, 32'h0000_03D9);
        repeat (2) @(posedge clk);
        check({31'h0, modeFlags.receiveSettled}, 32'h0);
        $display("test receive_flow done");
    endtask : receive_flow

    task automatic transmit_flow();
        apb(1'b1, adr(radio_flags_pkg::IDX_CONTROL), 32'h0000_03DB);
        sent <= 1'b1;
        @(posedge clk);
        sent <= 1'b0;
        repeat (2) @(posedge clk);
        check({24'h0, queueFlags}, 32'h0000_0008);
        check({31'h0, modeFlags.transmitSettled}, 32'h1);
        apb(1'b1, adr(radio_flags_pkg::IDX_CONTROL), 32'h0000_03D9);
        repeat (2) @(posedge clk);
        check({23'h0, queueFlags, modeFlags.transmitSettled}, 32'h0);
        $display("test transmit_flow done");
    endtask : transmit_flow

    // =========================================
    // verdict, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        reset_values();
        queue_levels();
        overflow_flush();
        receive_flow();
        transmit_flow();
        complete_run();
    end

    // the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        badCount++;
        complete_run();
    end
endmodule : tb_radio_irq_status_flags
`default_nettype wire
